/* pkg/icfm_pkg.sv */
// package: register map, field layout and timing constants of the clock monitor
package icfm_pkg;
	// register byte addresses (offsets printed as indices, byte address is four times)
	localparam int unsigned IDX_OVERRIDE = 'h5c;
	localparam int unsigned IDX_LOW = 'h5d;
	localparam int unsigned IDX_HIGH = 'h5e;
	localparam int unsigned IDX_MEAS = 'h5f;
	localparam int unsigned IDX_MODE = 'h5b;
	localparam int unsigned IDX_STATUS = 'h60;
	localparam int unsigned IDX_IRQ_STAT = 'h61;
	localparam int unsigned IDX_IRQ_MASK = 'h62;
	localparam logic [9:0] ADDR_OVERRIDE = 10'(IDX_OVERRIDE * 4);
	localparam logic [9:0] ADDR_LOW = 10'(IDX_LOW * 4);
	localparam logic [9:0] ADDR_HIGH = 10'(IDX_HIGH * 4);
	localparam logic [9:0] ADDR_MEAS = 10'(IDX_MEAS * 4);
	localparam logic [9:0] ADDR_MODE = 10'(IDX_MODE * 4);
	localparam logic [9:0] ADDR_STATUS = 10'(IDX_STATUS * 4);
	localparam logic [9:0] ADDR_IRQ_STAT = 10'(IDX_IRQ_STAT * 4);
	localparam logic [9:0] ADDR_IRQ_MASK = 10'(IDX_IRQ_MASK * 4);
	// field positions
	localparam int OVR_SWAP_DIS = 7;
	localparam int OVR_LINK_RDY = 6;
	localparam int OVR_CLK_DET = 5;
	localparam int OVR_STBL_HI = 4;
	localparam int OVR_STBL_LO = 3;
	localparam int OVR_HYST_HI = 2;
	localparam int LOW_RST_MODE = 6;
	localparam int MODE_SWAP = 6;
	localparam int MODE_RST_LOOP = 5;
	localparam int MODE_SRC_SEL = 4;
	// reset values
	localparam logic [7:0] RST_OVERRIDE = 8'h02;
	localparam logic [7:0] RST_LOW = 8'h06;
	localparam logic [7:0] RST_HIGH = 8'h2c;
	localparam logic [7:0] RST_MODE = 8'h20;
	// interrupt bits
	localparam int IRQ_CHANGE = 0;
	localparam int IRQ_STABLE = 1;
	localparam int IRQ_LOW = 2;
	localparam int IRQ_HIGH = 3;
	localparam int IRQ_W = 4;
	// timing
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned STBL_T0_US = 40;
	localparam int unsigned STBL_T1_US = 80;
	localparam int unsigned STBL_T2_US = 320;
	localparam int unsigned STBL_T3_US = 1280;
	localparam int unsigned STBL_C0 = STBL_T0_US * CLK_MHZ;
	localparam int unsigned STBL_C1 = STBL_T1_US * CLK_MHZ;
	localparam int unsigned STBL_C2 = STBL_T2_US * CLK_MHZ;
	localparam int unsigned STBL_C3 = STBL_T3_US * CLK_MHZ;
	// 1 us window: edges counted equal the rate in MHz
	localparam int unsigned WIN_US = 1;
	localparam int unsigned WIN_CYC = WIN_US * CLK_MHZ;
	localparam logic [1:0] SRC_RAW = 2'h0;

	typedef struct packed {
		logic [7:0] mhz;
		logic valid;
	} icfm_meas_t;
endpackage : icfm_pkg

/* hdl/icfm_rate_counter.sv */
// edge counter: measures the selected link or loop clock in whole MHz over a 1 us window
`timescale 1ns/1ns
module icfm_rate_counter #(
	parameter int WIN = icfm_pkg::WIN_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_in,
	output icfm_pkg::icfm_meas_t meas
);
	initial
	begin
		if (WIN < 2 || WIN > 255)
			$error("window length out of range");
	end

	logic sync1_reg, sync2_reg, prev_reg;
	logic [7:0] win_reg, win_next;
	logic [7:0] edge_reg, edge_next;
	icfm_pkg::icfm_meas_t meas_reg, meas_next;
	logic rise;

	assign rise = sync2_reg & ~prev_reg;
	assign meas = meas_reg;

	always_comb
	begin
		win_next = win_reg + 8'h01;
		edge_next = edge_reg;
		meas_next = meas_reg;
		meas_next.valid = 1'b0;
		if (rise && edge_reg != 8'hff)
			edge_next = edge_reg + 8'h01;
		if (win_reg == 8'(WIN - 1))
		begin
			win_next = 8'h00;
			edge_next = 8'h00;
			meas_next.mhz = edge_reg + {7'h00, rise};
			meas_next.valid = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
			win_reg <= 8'h00;
			edge_reg <= 8'h00;
			meas_reg <= '0;
		end
		else
		begin
			sync1_reg <= clk_in;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
			win_reg <= win_next;
			edge_reg <= edge_next;
			meas_reg <= meas_next;
		end
	end
endmodule : icfm_rate_counter

/* hdl/icfm_top.sv */
// input clock frequency monitor with Avalon-MM register file
`timescale 1ns/1ns
module icfm_top #(
	parameter int STBL0 = icfm_pkg::STBL_C0,
	parameter int STBL1 = icfm_pkg::STBL_C1,
	parameter int STBL2 = icfm_pkg::STBL_C2,
	parameter int STBL3 = icfm_pkg::STBL_C3
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic link_clk,
	input wire logic loop_clk,
	input wire logic rx_signal_valid,
	input wire logic supply_5v_detect,
	input wire logic back_channel_ready,
	input wire logic swap_detected,
	output logic link_ready,
	output logic clock_valid,
	output logic clock_too_slow,
	output logic rx_front_reset,
	output logic loop_reset,
	output logic link_swap,
	output logic irq
);
	initial
	begin
		if (STBL0 < 1 || STBL1 < STBL0 || STBL2 < STBL1 || STBL3 < STBL2 || STBL3 > 65535)
			$error("stability counts invalid");
	end

	// two-stage sync of pin levels
	logic [3:0] pin_s1_reg, pin_s2_reg;
	logic valid_s, v5_s, bc_s, swdet_s;
	assign {valid_s, v5_s, bc_s, swdet_s} = pin_s2_reg;

	logic meas_clk;
	icfm_pkg::icfm_meas_t meas;
	logic [7:0] override_reg, override_next;
	logic [7:0] low_reg, low_next;
	logic [7:0] high_reg, high_next;
	logic [7:0] mode_reg, mode_next;
	logic [7:0] held_reg, held_next;
	logic [15:0] stbl_reg, stbl_next;
	logic settled_reg, settled_next;
	logic [3:0] istat_reg, istat_next;
	logic [3:0] imask_reg, imask_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next;
	logic [15:0] stbl_lim;
	logic [7:0] diff;
	logic change, slow, high_hit, mode_change;
	logic [3:0] ev;
	logic [1:0] stsel;
	logic [1:0] clk_s1_reg, clk_s2_reg;
	logic win_ok_reg, win_ok_next;

	// both candidate clocks pass two flops before the source mux
	assign meas_clk = mode_reg[icfm_pkg::MODE_SRC_SEL]
		? clk_s2_reg[1] : clk_s2_reg[0];

	icfm_rate_counter #(
		.WIN(icfm_pkg::WIN_CYC)
	) u_cnt (
		.ref_clk(ref_clk),
		.srst(srst),
		.clk_in(meas_clk),
		.meas(meas)
	);

	assign stsel = override_reg[icfm_pkg::OVR_STBL_HI:icfm_pkg::OVR_STBL_LO];
	always_comb
	begin
		case (stsel)
			2'h0: stbl_lim = 16'(STBL0);
			2'h1: stbl_lim = 16'(STBL1);
			2'h2: stbl_lim = 16'(STBL2);
			2'h3: stbl_lim = 16'(STBL3);
			default: stbl_lim = 16'(STBL0);
		endcase
	end

	assign diff = (meas.mhz > held_reg) ? meas.mhz - held_reg : held_reg - meas.mhz;
	assign change = meas.valid && valid_s && win_ok_reg
		&& diff > {5'h00, override_reg[icfm_pkg::OVR_HYST_HI:0]};
	assign slow = held_reg < {2'h0, low_reg[5:0]};
	assign high_hit = held_reg > {1'h0, high_reg[6:0]};
	assign mode_change = (avs_write && ack_reg && avs_address == icfm_pkg::ADDR_MODE);

	// measurement, stability, outputs
	always_comb
	begin
		held_next = held_reg;
		stbl_next = stbl_reg;
		settled_next = settled_reg;
		win_ok_next = win_ok_reg;
		// window cut by signal return is partial: dropped
		if (!valid_s)
			win_ok_next = 1'b0;
		else if (meas.valid)
			win_ok_next = 1'b1;
		if (!valid_s)
		begin
			held_next = 8'h00;
			stbl_next = 16'h0000;
			settled_next = 1'b0;
		end
		else if (change)
		begin
			held_next = meas.mhz;
			stbl_next = 16'h0000;
			settled_next = 1'b0;
		end
		else if (stbl_reg >= stbl_lim - 16'h0001)
			settled_next = 1'b1;
		else
			stbl_next = stbl_reg + 16'h0001;
	end

	assign clock_too_slow = valid_s & slow;
	assign clock_valid = override_reg[icfm_pkg::OVR_CLK_DET]
		| (valid_s & settled_reg & ~slow & ~high_hit);
	assign link_ready = override_reg[icfm_pkg::OVR_LINK_RDY] | bc_s;
	assign loop_reset = change & mode_reg[icfm_pkg::MODE_RST_LOOP];
	assign rx_front_reset = (change | mode_change)
		& ~(low_reg[icfm_pkg::LOW_RST_MODE] & v5_s);
	assign link_swap = mode_reg[icfm_pkg::MODE_SWAP];

	assign ev[icfm_pkg::IRQ_CHANGE] = change;
	assign ev[icfm_pkg::IRQ_STABLE] = settled_next & ~settled_reg;
	assign ev[icfm_pkg::IRQ_LOW] = clock_too_slow;
	assign ev[icfm_pkg::IRQ_HIGH] = valid_s & high_hit;
	assign irq = |(istat_reg & imask_reg);
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign avs_readdata = rdata_reg;

	// bus response; one wait state per access
	always_comb
	begin
		rdata_next = rdata_reg;
		ack_next = 1'b0;
		if ((avs_read || avs_write) && !ack_reg)
		begin
			ack_next = 1'b1;
			rdata_next = 32'h0000_0000;
			if (avs_read)
			begin
				case (avs_address)
					icfm_pkg::ADDR_OVERRIDE: rdata_next[7:0] = override_reg;
					icfm_pkg::ADDR_LOW: rdata_next[6:0] = low_reg[6:0];
					icfm_pkg::ADDR_HIGH: rdata_next[6:0] = high_reg[6:0];
					icfm_pkg::ADDR_MEAS: rdata_next[7:0] = held_reg;
					icfm_pkg::ADDR_MODE: rdata_next[7:0] = mode_reg;
					icfm_pkg::ADDR_STATUS: rdata_next[0] = settled_reg;
					icfm_pkg::ADDR_IRQ_STAT: rdata_next[3:0] = istat_reg;
					icfm_pkg::ADDR_IRQ_MASK: rdata_next[3:0] = imask_reg;
					default: rdata_next = 32'h0000_0000;
				endcase
			end
		end
	end

	// control registers; writes land at the completion edge
	always_comb
	begin
		override_next = override_reg;
		low_next = low_reg;
		high_next = high_reg;
		mode_next = mode_reg;
		imask_next = imask_reg;
		if (!override_reg[icfm_pkg::OVR_SWAP_DIS])
			mode_next[icfm_pkg::MODE_SWAP] = swdet_s;
		if (avs_write && ack_reg && avs_byteenable[0])
		begin
			case (avs_address)
				icfm_pkg::ADDR_OVERRIDE: override_next = avs_writedata[7:0];
				icfm_pkg::ADDR_LOW: low_next = {1'b0, avs_writedata[6:0]};
				icfm_pkg::ADDR_HIGH: high_next = {1'b0, avs_writedata[6:0]};
				icfm_pkg::ADDR_MODE:
				begin
					mode_next = avs_writedata[7:0];
					if (!override_reg[icfm_pkg::OVR_SWAP_DIS])
						mode_next[icfm_pkg::MODE_SWAP] = swdet_s;
				end
				icfm_pkg::ADDR_IRQ_MASK: imask_next = avs_writedata[3:0];
				default: imask_next = imask_reg;
			endcase
		end
	end

	// interrupt status: write one to clear, a new event wins
	always_comb
	begin
		istat_next = istat_reg;
		if (avs_write && ack_reg && avs_byteenable[0]
			&& avs_address == icfm_pkg::ADDR_IRQ_STAT)
			istat_next = istat_reg & ~avs_writedata[3:0];
		istat_next = istat_next | ev;
	end

	// pin level and clock synchronisers
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			pin_s1_reg <= 4'h0;
			pin_s2_reg <= 4'h0;
			clk_s1_reg <= 2'h0;
			clk_s2_reg <= 2'h0;
		end
		else
		begin
			pin_s1_reg <= {rx_signal_valid, supply_5v_detect, back_channel_ready, swap_detected};
			pin_s2_reg <= pin_s1_reg;
			clk_s1_reg <= {loop_clk, link_clk};
			clk_s2_reg <= clk_s1_reg;
		end
	end

	// measurement and stability state
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			held_reg <= 8'h00;
			stbl_reg <= 16'h0000;
			settled_reg <= 1'b0;
			win_ok_reg <= 1'b0;
		end
		else
		begin
			held_reg <= held_next;
			stbl_reg <= stbl_next;
			settled_reg <= settled_next;
			win_ok_reg <= win_ok_next;
		end
	end

	// control registers
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			override_reg <= icfm_pkg::RST_OVERRIDE;
			low_reg <= icfm_pkg::RST_LOW;
			high_reg <= icfm_pkg::RST_HIGH;
			mode_reg <= icfm_pkg::RST_MODE;
			imask_reg <= 4'h0;
		end
		else
		begin
			override_reg <= override_next;
			low_reg <= low_next;
			high_reg <= high_next;
			mode_reg <= mode_next;
			imask_reg <= imask_next;
		end
	end

	// interrupt status
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			istat_reg <= 4'h0;
		else
			istat_reg <= istat_next;
	end

	// bus response
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			rdata_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
		end
	end
endmodule : icfm_top

/* sim/icfm_src_model.sv */
// video source model: link clock 160 ns and receiver loop clock 100 ns
`timescale 1ns/1ns
module icfm_src_model (
	input wire logic src_on,
	output logic link_clk,
	output logic loop_clk
);
	// both clocks stand still while the source is off
	initial
	begin
		link_clk = 1'b0;
		#7;
		forever
		begin
			#80;
			link_clk = src_on ? ~link_clk : 1'b0;
		end
	end
	initial
	begin
		loop_clk = 1'b0;
		#3;
		forever
		begin
			#50;
			loop_clk = src_on ? ~loop_clk : 1'b0;
		end
	end
endmodule : icfm_src_model

/* sim/icfm_chk.sv */
// checker: bus timing and override effects at the monitor's ports
`timescale 1ns/1ns
module icfm_chk (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic link_ready,
	input wire logic clock_valid,
	input wire logic clock_too_slow,
	input wire logic rx_front_reset,
	input wire logic link_swap
);
	logic [7:0] ovr_reg, ovr_next, low_reg, low_next;
	logic wdone;
	assign wdone = avs_write && !avs_waitrequest && avs_byteenable[0];
	// shadow of the override and low-limit registers
	always_comb
	begin
		ovr_next = ovr_reg;
		low_next = low_reg;
		if (wdone && avs_address == icfm_pkg::ADDR_OVERRIDE)
			ovr_next = avs_writedata[7:0];
		if (wdone && avs_address == icfm_pkg::ADDR_LOW)
			low_next = avs_writedata[7:0];
		if (srst)
		begin
			ovr_next = icfm_pkg::RST_OVERRIDE;
			low_next = icfm_pkg::RST_LOW;
		end
	end
	always_ff @(posedge ref_clk)
	begin
		ovr_reg <= ovr_next;
		low_reg <= low_next;
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	bus_one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	bus_first_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest)
		else $error("bus answered without wait state");
	upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 10'h3fc
		|-> avs_readdata == 32'h0) else $error("unmapped read not zero");
	force_ready_a: assert property (ovr_reg[6] |-> link_ready)
		else $error("forced link ready missing");
	force_valid_a: assert property (ovr_reg[5] |-> clock_valid)
		else $error("forced clock valid missing");
	slow_invalid_a: assert property (clock_too_slow && !ovr_reg[5] |-> !clock_valid)
		else $error("slow clock reported valid");
	mode_reset_a: assert property (wdone && avs_address == icfm_pkg::ADDR_MODE && !low_reg[6]
		|-> ##[0:2] rx_front_reset) else $error("no receiver reset on mode write");
	swap_hold_a: assert property (ovr_reg[7] && !wdone |=> $stable(link_swap))
		else $error("swap changed while correction off");
	cover property (ovr_reg[6]);
	cover property (rx_front_reset);
	cover property (avs_read && !avs_waitrequest && avs_address == 10'h3fc);
endmodule : icfm_chk
bind icfm_top icfm_chk chk_i (.ref_clk, .srst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .link_ready,
	.clock_valid, .clock_too_slow, .rx_front_reset, .link_swap);

/* sim/testbench.sv */
// bench: register bus, link source and reference model for the clock monitor
`timescale 1ns/1ns
module testbench;
	localparam logic [9:0] AO = icfm_pkg::ADDR_OVERRIDE;
	localparam logic [9:0] AL = icfm_pkg::ADDR_LOW;
	localparam logic [9:0] AH = icfm_pkg::ADDR_HIGH;
	localparam logic [9:0] AM = icfm_pkg::ADDR_MODE;
	localparam logic [9:0] AK = icfm_pkg::ADDR_IRQ_MASK;
	localparam int ST[4] = '{20, 40, 80, 160};
	logic ref_clk, srst, avs_read, avs_write, avs_waitrequest, link_clk, loop_clk, irq;
	logic rx_signal_valid, supply_5v_detect, back_channel_ready, swap_detected, link_swap;
	logic link_ready, clock_valid, clock_too_slow, rx_front_reset, loop_reset;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable = 4'h1;
	int errors = 0, check_count = 0, lr_n = 0, rf_n = 0, n, k, m;
	int mdl[int], msk[int];
	icfm_top #(.STBL0(20), .STBL1(40), .STBL2(80), .STBL3(160)) uut (.ref_clk, .srst,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .link_clk, .loop_clk, .rx_signal_valid, .supply_5v_detect,
		.back_channel_ready, .swap_detected, .link_ready, .clock_valid, .clock_too_slow,
		.rx_front_reset, .loop_reset, .link_swap, .irq);
	icfm_src_model src (.src_on(rx_signal_valid), .link_clk, .loop_clk);
	initial
	begin
		ref_clk = 1'b0;
		forever
			#10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		lr_n += loop_reset;
		rf_n += rx_front_reset;
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic print_verdict;
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic cyc(input int c);
		repeat (c) @(posedge ref_clk);
	endtask : cyc
	task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
		if (n >= 50)
		begin
			errors++;
			print_verdict();
		end
	endtask : bus
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
		if (msk.exists(a))
			mdl[a] = d & msk[a];
		// swap bit takes writes only with auto-correction off
		if (a == AM && (mdl[AO] & 'h80) != 0)
			mdl[a] = d;
		if (a == AO && !d[7])
			mdl[AM] = mdl[AM] & 'hbf;
	endtask : wr
	task automatic rd(input logic [9:0] a, input string nm);
		bus(a, 1'b0, 8'h0);
		chk(nm, q, 32'(mdl[a]));
	endtask : rd
	// source off, rate must read zero, then count cycles until clock valid
	task automatic tog;
		rx_signal_valid <= 1'b0;
		cyc(150);
		bus(icfm_pkg::ADDR_MEAS, 1'b0, 8'h0);
		chk("rate_off", q, 32'h0);
		rx_signal_valid <= 1'b1;
		for (k = 0; k < 600 && clock_valid !== 1'b1; k++)
			cyc(1);
	endtask : tog
	initial
	begin
		srst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 10'h0;
		avs_writedata = 32'h0;
		rx_signal_valid = 1'b0;
		supply_5v_detect = 1'b0;
		back_channel_ready = 1'b0;
		swap_detected = 1'b0;
		mdl[AO] = 'h02;
		msk[AO] = 'hff;
		mdl[AL] = 'h06;
		msk[AL] = 'h7f;
		mdl[AH] = 'h2c;
		msk[AH] = 'h7f;
		mdl[AM] = 'h20;
		msk[AM] = 'hbf;
		mdl[AK] = 'h00;
		msk[AK] = 'h0f;
		void'($urandom(43));
		cyc(5);
		srst <= 1'b0;
		cyc(1);
		foreach (mdl[a])
			rd(10'(a), "reset");
		bus(10'h3fc, 1'b0, 8'h0);
		chk("unmapped", q, 32'h0);
		repeat (3)
			foreach (mdl[a])
			begin
				wr(10'(a), 8'($urandom));
				rd(10'(a), "rw");
			end
		wr(AO, 8'h02);
		wr(AL, 8'h06);
		wr(AH, 8'h2c);
		wr(AM, 8'h20);
		wr(AO, 8'h22);
		chk("clk_force", clock_valid, 1'b1);
		wr(AO, 8'h42);
		chk("rdy_force", link_ready, 1'b1);
		wr(AO, 8'h02);
		chk("rdy_off", link_ready, 1'b0);
		chk("clk_real", clock_valid, 1'b0);
		back_channel_ready <= 1'b1;
		cyc(4);
		chk("rdy_on", link_ready, 1'b1);
		wr(AK, 8'h02);
		for (int c = 0; c < 4; c++)
		begin
			wr(AO, 8'(c * 8 + 2));
			m = lr_n;
			tog();
			chk("settle_lo", k > ST[c], 1'b1);
			chk("settle_hi", k < ST[c] + 250, 1'b1);
			chk("loop_rst", lr_n > m, 1'b1);
			bus(icfm_pkg::ADDR_STATUS, 1'b0, 8'h0);
			chk("settled", q, 32'h1);
			bus(icfm_pkg::ADDR_MEAS, 1'b0, 8'h0);
			chk("rate", q >= 1000 / 160 && q <= 1000 / 160 + 1, 1'b1);
			chk("irq_on", irq, 1'b1);
			wr(icfm_pkg::ADDR_IRQ_STAT, 8'hff);
			chk("irq_off", irq, 1'b0);
		end
		wr(AL, 8'h0a);
		chk("slow", clock_too_slow, 1'b1);
		chk("valid_lo", clock_valid, 1'b0);
		wr(AL, 8'h06);
		wr(AH, 8'h05);
		chk("valid_hi", clock_valid, 1'b0);
		wr(AH, 8'h2c);
		chk("valid_back", clock_valid, 1'b1);
		wr(AM, 8'h30);
		cyc(400);
		bus(icfm_pkg::ADDR_MEAS, 1'b0, 8'h0);
		chk("loop_src", q >= 1000 / 100 - 1 && q <= 1000 / 100 + 1, 1'b1);
		wr(AM, 8'h20);
		cyc(300);
		wr(AL, 8'h46);
		supply_5v_detect <= 1'b1;
		m = rf_n;
		tog();
		chk("rx_rst_off", rf_n, m);
		wr(AL, 8'h06);
		m = rf_n;
		tog();
		chk("rx_rst_on", rf_n > m, 1'b1);
		swap_detected <= 1'b1;
		cyc(4);
		chk("swap_auto", link_swap, 1'b1);
		wr(AM, 8'h20);
		chk("swap_held", link_swap, 1'b1);
		wr(AO, 8'h82);
		wr(AM, 8'h20);
		chk("swap_sw0", link_swap, 1'b0);
		wr(AM, 8'h60);
		chk("swap_sw1", link_swap, 1'b1);
		print_verdict();
	end
endmodule : testbench
